// File: gpmc_pkg.sv
// package: constants for the gpio pad mode control block
package gpmc_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0] PAD_CTRL_ADDR = 8'h00_b5;
  localparam logic [7:0] PORT0_OUT_ADDR = 8'h00_80;
  localparam logic [7:0] PORT0_CFG_ADDR = 8'h00_a4;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int BIT_STROBE = 7;
  localparam int BIT_PULLUP_OFF = 6;
  localparam int BIT_MATRIX = 5;
  localparam int BIT_DOUBLE_DRIVE = 4;
  localparam int BIT_LED_MID_TRIP = 3;
  localparam int BIT_PIN_MID_TRIP = 2;
  localparam int LED_PIN = 5;
  // --------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------
  localparam logic [7:0] PAD_CTRL_RESET = 8'h00_0c;
  localparam logic [7:0] PORT0_OUT_RESET = 8'h00_00;
  localparam logic [7:0] PORT0_CFG_RESET = 8'h00_00;
  localparam int CAPTURE_CYCLES = 2;
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_LOW = 2'h1;
  localparam logic [1:0] LED_MID = 2'h2;
  localparam logic [1:0] LED_HIGH = 2'h3;
endpackage

// File: gpmc_mode_latch.sv
// module: one pad permanent mode latch with strobe and capture delay
`timescale 1ns/1ps
`default_nettype none
module gpmc_mode_latch (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic strobe,
  input wire logic value,
  // state
  output logic mode,
  output logic busy
);
  logic held;
  logic next_held;
  logic [1:0] delay;
  logic [1:0] next_delay;
  logic strobe_d;
  logic next_strobe_d;

  // transparent while strobe is high, closes as it falls; busy stays two clocks more
  always_comb begin
    next_strobe_d = strobe;
    next_held = held;
    next_delay = delay;
    if (strobe) begin
      next_held = value;
      next_delay = 2'(gpmc_pkg::CAPTURE_CYCLES);
    end else if (delay != 2'h0) begin
      next_delay = 2'(delay - 2'h1);
    end
  end

  // reset clears the latch too; real pads would keep it, kept simple here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      held <= 1'b0;
      delay <= 2'h0;
      strobe_d <= 1'b0;
    end else begin
      held <= next_held;
      delay <= next_delay;
      strobe_d <= next_strobe_d;
    end
  end

  assign mode = held;
  assign busy = strobe | (delay != 2'h0);

  // captured value stands once the strobe has fallen
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!strobe && !$past(strobe)) |-> $stable(held))
    else $error("mode latch changed while closed");
  a_latch_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
    strobe |=> (held == $past(value)))
    else $error("mode latch not transparent during strobe");
  a_capture_done: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($fell(strobe_d) && !strobe) |-> ##[0:2] !busy)
    else $error("capture took more than two clocks");
endmodule
`default_nettype wire

// File: gpmc_top.sv
// module: gpio pad mode control register and pad steering
// Summary of operation
// - strobe high opens mode latches, passing pull-up-off and matrix bits to pads.
// - strobe written 0-1-0 captures both modes; done within two clocks.
// - pull-up-off bit reads back the latched pad value.
// - latched pull-up-off disables pull-ups on pins 1 and 2.
// - matrix bit reads back the latched pad value.
// - latched matrix drives pins 1 to 3 low, pull-ups off.
// - double-drive bit doubles output drive of all pins.
// - bit 3 sets pin 5 trip point to 45 percent supply.
// - bit 2 sets all other pins' trip point to 45 percent.
// - led field selects current: off, 0.62, 1.00, 1.62 of 600uA.
// - led on/off follows pin 5 bit of port 0 output register.
// - led field zero makes pin 5 output read as zero.
// - open-drain pins keep pull-up unless pull-up-off or matrix overrides; pin 5 has none.
`timescale 1ns/1ps
`default_nettype none
module gpmc_top #(
  parameter int PINS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // pad pins, output enable low while driving
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe_n,
  output logic [PINS-1:0] pad_pullup_en,
  // analog pad settings
  output logic double_drive,
  output logic led_pin_mid_trip,
  output logic pin_mid_trip,
  output logic [1:0] led_current_level,
  output logic led_enable,
  // pad mode latch state
  output logic pullup_off_mode,
  output logic matrix_mode,
  output logic mode_busy
);
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] pad_ctrl;
  logic [7:0] next_pad_ctrl;
  logic [7:0] port0_output_reg;
  logic [7:0] next_port0_output_reg;
  logic [7:0] port0_drive_config;
  logic [7:0] next_port0_drive_config;
  logic [7:0] next_sfr_rdata;
  logic busy_roff;
  logic busy_matrix;

  // write decode; the pad mode bits are stored as last written
  always_comb begin
    next_pad_ctrl = pad_ctrl;
    next_port0_output_reg = port0_output_reg;
    next_port0_drive_config = port0_drive_config;
    if (sfr_wr) begin
      case (sfr_addr)
        gpmc_pkg::PAD_CTRL_ADDR: begin
          next_pad_ctrl = sfr_wdata;
        end
        gpmc_pkg::PORT0_OUT_ADDR: begin
          next_port0_output_reg = sfr_wdata;
        end
        gpmc_pkg::PORT0_CFG_ADDR: begin
          next_port0_drive_config = sfr_wdata;
        end
        default: begin
          next_pad_ctrl = pad_ctrl;
        end
      endcase
    end
  end

  // register storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pad_ctrl <= gpmc_pkg::PAD_CTRL_RESET;
      port0_output_reg <= gpmc_pkg::PORT0_OUT_RESET;
      port0_drive_config <= gpmc_pkg::PORT0_CFG_RESET;
    end else begin
      pad_ctrl <= next_pad_ctrl;
      port0_output_reg <= next_port0_output_reg;
      port0_drive_config <= next_port0_drive_config;
    end
  end

  // ------------------------------------------------------------------
  // pad mode latches
  // ------------------------------------------------------------------
  gpmc_mode_latch u_roff (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .strobe(pad_ctrl[gpmc_pkg::BIT_STROBE]),
    .value(pad_ctrl[gpmc_pkg::BIT_PULLUP_OFF]),
    .mode(pullup_off_mode),
    .busy(busy_roff)
  );
  gpmc_mode_latch u_matrix (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .strobe(pad_ctrl[gpmc_pkg::BIT_STROBE]),
    .value(pad_ctrl[gpmc_pkg::BIT_MATRIX]),
    .mode(matrix_mode),
    .busy(busy_matrix)
  );
  assign mode_busy = busy_roff | busy_matrix;

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // mode bits come from the pads, so a write without strobe is not seen
  always_comb begin
    next_sfr_rdata = 8'h00_00;
    case (sfr_addr)
      gpmc_pkg::PAD_CTRL_ADDR: begin
        next_sfr_rdata = pad_ctrl;
        next_sfr_rdata[gpmc_pkg::BIT_PULLUP_OFF] = pullup_off_mode;
        next_sfr_rdata[gpmc_pkg::BIT_MATRIX] = matrix_mode;
      end
      gpmc_pkg::PORT0_OUT_ADDR: begin
        next_sfr_rdata = 8'(pad_in);
        next_sfr_rdata[gpmc_pkg::LED_PIN] = led_enable;
      end
      gpmc_pkg::PORT0_CFG_ADDR: begin
        next_sfr_rdata = port0_drive_config;
      end
      default: begin
        next_sfr_rdata = 8'h00_00;
      end
    endcase
  end

  // read data registered on a read strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00_00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  assign sfr_hit = (sfr_addr == gpmc_pkg::PAD_CTRL_ADDR) ||
                   (sfr_addr == gpmc_pkg::PORT0_OUT_ADDR) ||
                   (sfr_addr == gpmc_pkg::PORT0_CFG_ADDR);

  // ------------------------------------------------------------------
  // pad steering
  // ------------------------------------------------------------------
  assign double_drive = pad_ctrl[gpmc_pkg::BIT_DOUBLE_DRIVE];
  assign led_pin_mid_trip = pad_ctrl[gpmc_pkg::BIT_LED_MID_TRIP];
  assign pin_mid_trip = pad_ctrl[gpmc_pkg::BIT_PIN_MID_TRIP];
  assign led_current_level = pad_ctrl[1:0];
  // led switch follows the port bit, current level gates it
  assign led_enable = port0_output_reg[gpmc_pkg::LED_PIN] &&
                      (pad_ctrl[1:0] != gpmc_pkg::LED_OFF);

  // open drain drives only a low; matrix mode forces pins 1..3 low
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pad_out[i] = port0_output_reg[i];
      pad_oe_n[i] = port0_drive_config[i] ? 1'b0 : port0_output_reg[i];
      pad_pullup_en[i] = !port0_drive_config[i];
    end
    pad_oe_n[0] = 1'b1;
    pad_out[gpmc_pkg::LED_PIN] = led_enable;
    pad_oe_n[gpmc_pkg::LED_PIN] = !led_enable;
    pad_pullup_en[gpmc_pkg::LED_PIN] = 1'b0;
    if (pullup_off_mode) begin
      pad_pullup_en[1] = 1'b0;
      pad_pullup_en[2] = 1'b0;
    end
    if (matrix_mode) begin
      for (int j = 1; j <= 3; j++) begin
        pad_out[j] = 1'b0;
        pad_oe_n[j] = 1'b0;
        pad_pullup_en[j] = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_roff_pullups: assert property (@(posedge clk_sys) disable iff (!resetn)
    pullup_off_mode |-> (pad_pullup_en[2:1] == 2'h0))
    else $error("pull-ups on while pull-up-off latched");
  a_matrix_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    matrix_mode |-> (pad_oe_n[3:1] == 3'h0 && pad_out[3:1] == 3'h0))
    else $error("matrix pins not driven low");
  a_led_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    (led_current_level == gpmc_pkg::LED_OFF) |-> !led_enable)
    else $error("led enabled with zero current");
  a_led_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    (led_current_level != gpmc_pkg::LED_OFF) |->
      (led_enable == port0_output_reg[gpmc_pkg::LED_PIN]))
    else $error("led does not follow port bit");
  a_roff_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_rd && sfr_addr == gpmc_pkg::PAD_CTRL_ADDR) |=>
      (sfr_rdata[gpmc_pkg::BIT_PULLUP_OFF] == $past(pullup_off_mode)))
    else $error("pull-up-off read not from latch");
  a_matrix_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_rd && sfr_addr == gpmc_pkg::PAD_CTRL_ADDR) |=>
      (sfr_rdata[gpmc_pkg::BIT_MATRIX] == $past(matrix_mode)))
    else $error("matrix read not from latch");
  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_wr && sfr_addr == gpmc_pkg::PAD_CTRL_ADDR) |=>
      (double_drive == $past(sfr_wdata[4]) &&
       led_current_level == $past(sfr_wdata[1:0])))
    else $error("control write not applied");
  a_trip_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_wr && sfr_addr == gpmc_pkg::PAD_CTRL_ADDR) |=>
      (led_pin_mid_trip == $past(sfr_wdata[3]) &&
       pin_mid_trip == $past(sfr_wdata[2])))
    else $error("trip point write not applied");
endmodule
`default_nettype wire

// File: gpmc_pad_model.sv
// pad model: pins with buttons to ground and pull-up resistors
`timescale 1ns/1ps
`default_nettype none
module gpmc_pad_model (
  // clock
  input wire logic clk_sys,
  // pad side of the block
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_pullup_en,
  // buttons to ground, high while pressed
  input wire logic [7:0] button,
  output logic [7:0] pad_in
);
  logic drift = 1'b0;
  // a pin nobody drives or pulls wanders, so a stale level is never trusted
  always @(posedge clk_sys) begin
    drift <= ~drift;
  end
  // driven pin wins, then a pressed button, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (button[i]) pad_in[i] = 1'b0;
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = drift ^ i[0];
    end
  end
endmodule
`default_nettype wire

// File: gpmc_tb_top.sv
// testbench: pad mode control register driven over the register bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module gpmc_tb_top;
  logic clk_sys, resetn, sfr_wr, sfr_rd, sfr_hit;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, button, rd, v;
  logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup_en;
  logic double_drive, led_pin_mid_trip, pin_mid_trip, led_enable;
  logic [1:0] led_current_level;
  logic pullup_off_mode, matrix_mode, mode_busy;
  int num_errors = 0;
  int n_checks = 0;
  // --------------------------------------------------------------
  // design and pads
  // --------------------------------------------------------------
  gpmc_top #(.PINS(8)) gpmc_top_inst (.clk_sys(clk_sys), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pullup_en), .double_drive(double_drive),
    .led_pin_mid_trip(led_pin_mid_trip), .pin_mid_trip(pin_mid_trip),
    .led_current_level(led_current_level), .led_enable(led_enable),
    .pullup_off_mode(pullup_off_mode), .matrix_mode(matrix_mode),
    .mode_busy(mode_busy));
  gpmc_pad_model gpmc_pad_model_inst (.clk_sys(clk_sys), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en), .button(button),
    .pad_in(pad_in));
  // --------------------------------------------------------------
  // clock, bus tasks, closing
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // called at a falling edge; the rising edge between takes the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    // idle cycle so a following call never re-raises the strobe at once
    @(negedge clk_sys);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    rd = sfr_rdata;
    @(negedge clk_sys);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    num_errors++;
    $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    test_done();
  end
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, button} = '0;
    wait_cyc(6);
    resetn = 1'b1;
    rd_reg(gpmc_pkg::PAD_CTRL_ADDR);
    `CHK(rd, gpmc_pkg::PAD_CTRL_RESET)
    `CHK(sfr_hit, 1'b1)
    wr(8'h00_b6, 8'h00_ff);
    rd_reg(8'h00_b6);
    `CHK(rd, 8'h00_00)
    `CHK(sfr_hit, 1'b0)
    $display("test reset done");
    // open-drain outputs released so pads follow pull-ups and buttons
    wr(gpmc_pkg::PORT0_OUT_ADDR, 8'h00_ff);
    for (int l = 0; l < 4; l++) begin
      v = {3'b000, l[0], ~l[0], l[1], l[1:0]};
      wr(gpmc_pkg::PAD_CTRL_ADDR, v);
      rd_reg(gpmc_pkg::PAD_CTRL_ADDR);
      `CHK(rd, v)
      `CHK(double_drive, v[4])
      `CHK(led_pin_mid_trip, v[3])
      `CHK(pin_mid_trip, v[2])
      `CHK(led_current_level, v[1:0])
      `CHK(led_enable, (l != 0))
      rd_reg(gpmc_pkg::PORT0_OUT_ADDR);
      `CHK(rd[5], (l != 0))
    end
    $display("test fields done");
    // latch is transparent while the strobe stays high
    wr(gpmc_pkg::PAD_CTRL_ADDR, 8'h00_c0);
    wait_cyc(1);
    `CHK(mode_busy, 1'b1)
    wait_cyc(1);
    `CHK(pullup_off_mode, 1'b1)
    wr(gpmc_pkg::PAD_CTRL_ADDR, 8'h00_80);
    wait_cyc(2);
    `CHK(pullup_off_mode, 1'b0)
    wr(gpmc_pkg::PAD_CTRL_ADDR, 8'h00_c0);
    wait_cyc(2);
    wr(gpmc_pkg::PAD_CTRL_ADDR, 8'h00_00);
    wait_cyc(2);
    `CHK(mode_busy, 1'b0)
    `CHK(pullup_off_mode, 1'b1)
    rd_reg(gpmc_pkg::PAD_CTRL_ADDR);
    `CHK(rd[6], 1'b1)
    `CHK(pad_pullup_en[2:1], 2'b00)
    `CHK(pad_pullup_en[4], 1'b1)
    $display("test pull-up-off done");
    // matrix capture also clears the pull-up-off latch
    wr(gpmc_pkg::PAD_CTRL_ADDR, 8'h00_a0);
    wait_cyc(2);
    wr(gpmc_pkg::PAD_CTRL_ADDR, 8'h00_20);
    wait_cyc(2);
    rd_reg(gpmc_pkg::PAD_CTRL_ADDR);
    `CHK(rd[6:5], 2'b01)
    `CHK(matrix_mode, 1'b1)
    `CHK(pad_out[3:1], 3'b000)
    `CHK(pad_oe_n[3:1], 3'b000)
    `CHK(pad_pullup_en[3:1], 3'b000)
    $display("test matrix done");
    // open-drain input sees its pull-up; push-pull loses it
    button = 8'h00_01;
    wait_cyc(1);
    rd_reg(gpmc_pkg::PORT0_OUT_ADDR);
    `CHK(rd[0], 1'b0)
    button = 8'h00_00;
    wait_cyc(1);
    rd_reg(gpmc_pkg::PORT0_OUT_ADDR);
    `CHK(rd[0], 1'b1)
    wr(gpmc_pkg::PORT0_CFG_ADDR, 8'h00_10);
    rd_reg(gpmc_pkg::PORT0_CFG_ADDR);
    `CHK(rd, 8'h00_10)
    `CHK(pad_pullup_en[4], 1'b0)
    $display("test drive config done");
    test_done();
  end
endmodule
`undef CHK
`default_nettype wire
